// [dwt_top.sv]
`timescale 1ns/1ns
module dwt_top #(
	parameter int DIV_W = dwt_pkg::DIV_WIDTH, // Divider stages
	parameter int WDT_W = dwt_pkg::WDT_WIDTH // Watchdog stages
) (
	input wire logic clk, // System clock, 50 MHz
	input wire logic nrst, // Async reset, active low
	input wire logic wdt_option_pin, // Watchdog build option, async level
	input wire logic pmf_set_stb, // Set flag bits in pmf_mask
	input wire logic pmf_clr_stb, // Clear flag bits in pmf_mask
	input wire logic [3:0] pmf_mask, // Flag bit mask
	input wire logic wdt_clr_stb, // Watchdog clear instruction
	input wire logic div_clr_stb, // Divider upper stage clear
	input wire logic tm0_lo_stb, // Low nibble load
	input wire logic tm0_hi_stb, // High nibble load
	input wire logic tm0_imm_stb, // Immediate 8-bit load
	input wire logic [7:0] tm0_data, // Load value, nibble in [3:0]
	input wire logic mr0_wr_stb, // Timer 0 mode write
	input wire logic [3:0] mr0_data, // Timer 0 mode value
	input wire logic ief_wr_stb, // Interrupt enable write
	input wire logic hef_wr_stb, // Hold release enable write
	input wire logic [3:0] en_data, // Enable write value
	input wire logic evf_clr_stb, // Event flag clear
	input wire logic [1:0] evf_clr_mask, // Event flags to clear
	output logic [1:0] event_flags, // Event flag bits 1:0
	output logic div_irq, // Divider interrupt request
	output logic tm0_irq, // Timer 0 interrupt request
	output logic div_hold_release, // Divider hold release
	output logic tm0_hold_release, // Timer 0 hold release
	output logic chip_reset_req, // Watchdog reset pulse
	output logic [7:0] tm0_count, // Timer 0 value
	output logic tm0_running, // Timer 0 counting
	output logic [3:0] wdt_count, // Watchdog value
	output logic wdt_slow, // Watchdog prescale select
	output logic wdt_enabled // Watchdog option as sampled
);

	// ------------------------------------------------------------
	// Local constants
	// ------------------------------------------------------------
	localparam int UP_W = dwt_pkg::DIV_CLR_STAGES;
	// Lower stages keep counting through a divider clear
	localparam int LO_W = DIV_W - UP_W;
	// Fast watchdog tap, below the clearable stages
	localparam int TAP = dwt_pkg::WDT_FAST_TAP;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	// Option synchroniser
	logic opt_s1_ff;
	logic opt_s2_ff;
	logic opt_s3_ff;

	// Watchdog and divider
	logic wdt_en_ff;
	logic pmf_slow_ff;
	logic [DIV_W-1:0] div_ff;
	logic [LO_W-1:0] nxt_div_lo;
	logic [UP_W-1:0] nxt_div_up;
	logic div_lo_carry;
	logic div_ovf;
	logic wdt_tap_fast;
	logic wdt_tick;
	logic [WDT_W-1:0] wdt_ff;
	logic wdt_ovf;
	logic chip_rst_ff;

	// Timer 0 mode, events and enables
	logic mr0_presc_ff;
	logic [dwt_pkg::EVF_WIDTH-1:0] evf_ff;
	logic [dwt_pkg::EVF_WIDTH-1:0] ief_ff;
	logic [dwt_pkg::EVF_WIDTH-1:0] hef_ff;
	logic [dwt_pkg::EVF_WIDTH-1:0] evf_set;
	logic [dwt_pkg::EVF_WIDTH-1:0] evf_clr;
	logic [dwt_pkg::EVF_WIDTH-1:0] irq_ff;
	logic [dwt_pkg::EVF_WIDTH-1:0] hold_ff;

	// Run control to the timer core
	logic tm0_start;
	logic tm0_stop;

	dwt_tm0_if tm0_bus ();

	// ------------------------------------------------------------
	// Option pin synchroniser
	// ------------------------------------------------------------

	// Three stages; only the last two are compared
	// The first stage may go metastable, so nothing but the second reads it
	// The option is a strap level, so a few cycles of lag cost nothing
	// Reset holds all stages low, so the watchdog starts disabled
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			opt_s1_ff <= 1'b0;
			opt_s2_ff <= 1'b0;
			opt_s3_ff <= 1'b0;
		end else begin
			opt_s1_ff <= wdt_option_pin;
			opt_s2_ff <= opt_s1_ff;
			opt_s3_ff <= opt_s2_ff;
		end
	end

	// Watchdog stays off until the option is seen settled
	// A pin that never settles leaves the old value in place
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wdt_en_ff <= 1'b0;
		end else if (opt_s2_ff == opt_s3_ff) begin
			wdt_en_ff <= opt_s3_ff;
		end
	end

	// ------------------------------------------------------------
	// Parameter flag
	// ------------------------------------------------------------

	// Only bit 3 is kept; the reserved bits hold nothing
	// Set wins over clear when both strobes name bit 3
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pmf_slow_ff <= dwt_pkg::RST_PMF_WDT_SLOW;
		end else if (pmf_set_stb && pmf_mask[dwt_pkg::PMF_WDT_SLOW_BIT]) begin
			pmf_slow_ff <= 1'b1;
		end else if (pmf_clr_stb && pmf_mask[dwt_pkg::PMF_WDT_SLOW_BIT]) begin
			pmf_slow_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Periodic divider
	// ------------------------------------------------------------

	// Lower stages always advance; carry feeds the upper stages
	// Split at the clearable boundary so a clear only touches the top
	assign div_lo_carry = &div_ff[LO_W-1:0];
	assign nxt_div_lo = div_ff[LO_W-1:0] + 1'b1;

	// Upper stage clear beats the carry into them
	// A clear in the carry cycle still leaves the top stages at zero
	always_comb begin
		nxt_div_up = div_ff[DIV_W-1:LO_W];
		if (div_clr_stb) begin
			nxt_div_up = '0;
		end else if (div_lo_carry) begin
			nxt_div_up = div_ff[DIV_W-1:LO_W] + 1'b1;
		end
	end

	// Overflow lost if the upper stages are cleared in that cycle
	// The event then comes one full upper period after the clear
	assign div_ovf = (&div_ff) & ~div_clr_stb;

	// Wraps through zero without any software help
	// No reload value: the period is fixed by the width
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_ff <= dwt_pkg::RST_DIV;
		end else begin
			div_ff <= {nxt_div_up, nxt_div_lo};
		end
	end

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------

	// Fast tap sits below the clearable stages, so divider clear
	// never disturbs the Fosc/1024 rate; the slow rate it does stretch.
	assign wdt_tap_fast = &div_ff[TAP-1:0];
	assign wdt_tick = pmf_slow_ff ? div_ovf : wdt_tap_fast;

	// Clear wins over a coinciding tick
	// Overflow needs the enable and a count of all ones
	assign wdt_ovf = wdt_en_ff & wdt_tick & ~wdt_clr_stb & (&wdt_ff);

	// Counter; disabled means held at zero, not merely frozen
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wdt_ff <= dwt_pkg::RST_WDT;
		end else if (!wdt_en_ff || wdt_clr_stb) begin
			wdt_ff <= '0;
		end else if (wdt_tick) begin
			wdt_ff <= wdt_ff + 1'b1;
		end
	end

	// Single-cycle request to the chip reset logic
	// Outside logic must pull nrst; the block never resets itself
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chip_rst_ff <= 1'b0;
		end else begin
			chip_rst_ff <= wdt_ovf;
		end
	end

	// ------------------------------------------------------------
	// Timer 0 mode
	// ------------------------------------------------------------

	// Prescale choice is kept; the run bit lives in the core
	// Mode bits 1 and 2 are reserved and dropped
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mr0_presc_ff <= dwt_pkg::RST_MR0_PRESCALE;
		end else if (mr0_wr_stb) begin
			mr0_presc_ff <= mr0_data[dwt_pkg::MR0_PRESCALE_BIT];
		end
	end

	// Run control decoded from the mode write
	assign tm0_start = mr0_wr_stb & mr0_data[dwt_pkg::MR0_RUN_BIT];
	assign tm0_stop = mr0_wr_stb & ~mr0_data[dwt_pkg::MR0_RUN_BIT];

	// Drive the timer core
	// Plain wiring; all timer priority lives in the core
	assign tm0_bus.load_lo = tm0_lo_stb;
	assign tm0_bus.load_hi = tm0_hi_stb;
	assign tm0_bus.load_imm = tm0_imm_stb;
	assign tm0_bus.load_data = tm0_data;
	assign tm0_bus.start = tm0_start;
	assign tm0_bus.stop = tm0_stop;
	assign tm0_bus.slow_sel = mr0_presc_ff;

	dwt_tm0_core u_tm0 (
		.clk(clk),
		.nrst(nrst),
		.tm(tm0_bus.core)
	);

	// ------------------------------------------------------------
	// Event flags
	// ------------------------------------------------------------

	// Hardware events that raise a flag
	// Both sources are single-cycle pulses
	always_comb begin
		evf_set = '0;
		evf_set[dwt_pkg::EVF_DIV_BIT] = div_ovf;
		evf_set[dwt_pkg::EVF_TM0_BIT] = tm0_bus.underflow;
	end

	// Software clear plus the clear implied by a timer start
	// The implied clear only touches the timer flag
	always_comb begin
		evf_clr = evf_clr_stb ? evf_clr_mask : '0;
		if (tm0_start) begin
			evf_clr[dwt_pkg::EVF_TM0_BIT] = 1'b1;
		end
	end

	// Sticky; a set in the clearing cycle is kept
	// so an event that meets a clear is never lost
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			evf_ff <= dwt_pkg::RST_EVF;
		end else begin
			evf_ff <= (evf_ff & ~evf_clr) | evf_set;
		end
	end

	// ------------------------------------------------------------
	// Enables
	// ------------------------------------------------------------

	// Only the two bits this block serves are held here
	// Bits 3:2 of the enable value belong to other blocks
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ief_ff <= dwt_pkg::RST_EN;
		end else if (ief_wr_stb) begin
			ief_ff <= en_data[dwt_pkg::EVF_WIDTH-1:0];
		end
	end

	// Hold release enables, same shape as the interrupt enables
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hef_ff <= dwt_pkg::RST_EN;
		end else if (hef_wr_stb) begin
			hef_ff <= en_data[dwt_pkg::EVF_WIDTH-1:0];
		end
	end

	// ------------------------------------------------------------
	// Requests
	// ------------------------------------------------------------

	// Registered so the requests are glitch free; costs one cycle
	// Levels follow the flags; clearing a flag withdraws its request
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_ff <= '0;
			hold_ff <= '0;
		end else begin
			irq_ff <= evf_ff & ief_ff;
			hold_ff <= evf_ff & hef_ff;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------

	// Event flags and requests
	assign event_flags = evf_ff;
	assign div_irq = irq_ff[dwt_pkg::EN_DIV_BIT];
	assign tm0_irq = irq_ff[dwt_pkg::EN_TM0_BIT];
	assign div_hold_release = hold_ff[dwt_pkg::EN_DIV_BIT];
	assign tm0_hold_release = hold_ff[dwt_pkg::EN_TM0_BIT];

	// Watchdog and timer state, all from registers
	assign chip_reset_req = chip_rst_ff;
	assign tm0_count = tm0_bus.count;
	assign tm0_running = tm0_bus.running;
	assign wdt_count = wdt_ff;
	assign wdt_slow = pmf_slow_ff;
	assign wdt_enabled = wdt_en_ff;

endmodule : dwt_top

// [dwt_pkg.sv]
package dwt_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int DIV_WIDTH = 14;
	localparam int DIV_CLR_STAGES = 4;
	localparam int WDT_WIDTH = 4;
	localparam int TM0_WIDTH = 8;
	localparam int NIBBLE_WIDTH = 4;
	localparam int PRESC_WIDTH = 10;

	// ------------------------------------------------------------
	// Prescale factors in system clock periods
	// ------------------------------------------------------------
	localparam int TM0_FAST_DIV = 4;
	localparam int TM0_SLOW_DIV = 1024;
	localparam int WDT_FAST_DIV = 1024;
	localparam int WDT_SLOW_DIV = 16384;
	localparam int WDT_FAST_TAP = $clog2(WDT_FAST_DIV);

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int PMF_WDT_SLOW_BIT = 3;
	localparam int MR0_PRESCALE_BIT = 0;
	localparam int MR0_RUN_BIT = 3;
	localparam int EVF_DIV_BIT = 0;
	localparam int EVF_TM0_BIT = 1;
	localparam int EVF_WIDTH = 2;
	localparam int EN_DIV_BIT = 0;
	localparam int EN_TM0_BIT = 1;

	// ------------------------------------------------------------
	// Reset values and timer underflow value
	// ------------------------------------------------------------
	localparam logic RST_PMF_WDT_SLOW = 1'h0;
	localparam logic RST_MR0_PRESCALE = 1'h0;
	localparam logic [EVF_WIDTH-1:0] RST_EVF = 2'h0;
	localparam logic [EVF_WIDTH-1:0] RST_EN = 2'h0;
	localparam logic [TM0_WIDTH-1:0] RST_TM0 = 8'h00;
	localparam logic [TM0_WIDTH-1:0] TM0_UNDERFLOW_VALUE = 8'hFF;
	localparam logic [DIV_WIDTH-1:0] RST_DIV = 14'h0000;
	localparam logic [WDT_WIDTH-1:0] RST_WDT = 4'h0;

endpackage : dwt_pkg

// [dwt_tm0_if.sv]
`timescale 1ns/1ns
interface dwt_tm0_if;
	logic load_lo;
	logic load_hi;
	logic load_imm;
	logic [dwt_pkg::TM0_WIDTH-1:0] load_data;
	logic start;
	logic stop;
	logic slow_sel;
	logic [dwt_pkg::TM0_WIDTH-1:0] count;
	logic running;
	logic underflow;

	// Control side in the top, counting side in the core
	modport ctrl (
		output load_lo, load_hi, load_imm, load_data, start, stop, slow_sel,
		input count, running, underflow
	);
	modport core (
		input load_lo, load_hi, load_imm, load_data, start, stop, slow_sel,
		output count, running, underflow
	);
endinterface : dwt_tm0_if

// [dwt_tm0_core.sv]
`timescale 1ns/1ns
module dwt_tm0_core (
	input wire logic clk, // System clock
	input wire logic nrst, // Async reset, active low
	dwt_tm0_if.core tm // Timer 0 control and status
);

	localparam int NW = dwt_pkg::NIBBLE_WIDTH;
	localparam int TW = dwt_pkg::TM0_WIDTH;
	localparam int PW = dwt_pkg::PRESC_WIDTH;
	localparam logic [PW-1:0] FAST_LAST = PW'(dwt_pkg::TM0_FAST_DIV - 1);
	localparam logic [PW-1:0] SLOW_LAST = PW'(dwt_pkg::TM0_SLOW_DIV - 1);

	logic [dwt_pkg::PRESC_WIDTH-1:0] presc_ff;
	logic [TW-1:0] count_ff;
	logic running_ff;
	logic underflow_ff;
	logic any_load;
	logic tick;

	assign any_load = tm.load_lo | tm.load_hi | tm.load_imm;
	// Tick on the last cycle of each prescale period
	assign tick = running_ff & (presc_ff == (tm.slow_sel ? SLOW_LAST : FAST_LAST));

	// Prescaler restarts with each start so the first period is whole
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			presc_ff <= '0;
		end else if (tm.start || !running_ff || tick) begin
			presc_ff <= '0;
		end else begin
			presc_ff <= presc_ff + 1'b1;
		end
	end

	// Counter: loads win over counting; start does not touch the count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_ff <= dwt_pkg::RST_TM0;
		end else if (tm.load_imm) begin
			count_ff <= tm.load_data;
		end else if (tm.load_lo || tm.load_hi) begin
			if (tm.load_lo) count_ff[NW-1:0] <= tm.load_data[NW-1:0];
			if (tm.load_hi) count_ff[TW-1:NW] <= tm.load_data[NW-1:0];
		end else if (tick) begin
			count_ff <= count_ff - 1'b1;
		end
	end

	// Run state; underflow stops without reload
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			running_ff <= 1'b0;
		end else if (any_load || tm.stop) begin
			running_ff <= 1'b0;
		end else if (tm.start) begin
			running_ff <= 1'b1;
		end else if (tick && count_ff == '0) begin
			running_ff <= 1'b0;
		end
	end

	// One-cycle underflow pulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			underflow_ff <= 1'b0;
		end else begin
			underflow_ff <= tick & (count_ff == '0) & ~any_load & ~tm.stop & ~tm.start;
		end
	end

	assign tm.count = count_ff;
	assign tm.running = running_ff;
	assign tm.underflow = underflow_ff;

endmodule : dwt_tm0_core

// [dwt_checker.sv]
`timescale 1ns/1ns
module dwt_checker #(
	parameter int DIV_W = 14, // Divider stages
	parameter int WDT_W = 4 // Watchdog stages
) (
	input wire logic clk, // Clock
	input wire logic nrst, // Reset
	input wire logic pmf_set_stb, // Flag set
	input wire logic pmf_clr_stb, // Flag clear
	input wire logic [3:0] pmf_mask, // Flag mask
	input wire logic wdt_clr_stb, // Watchdog clear
	input wire logic tm0_lo_stb, // Low load
	input wire logic tm0_hi_stb, // High load
	input wire logic tm0_imm_stb, // Full load
	input wire logic [7:0] tm0_data, // Load value
	input wire logic mr0_wr_stb, // Mode write
	input wire logic [3:0] mr0_data, // Mode value
	input wire logic evf_clr_stb, // Event clear
	input wire logic [1:0] evf_clr_mask, // Event mask
	input wire logic [1:0] event_flags, // Events
	input wire logic tm0_irq, // Timer request
	input wire logic chip_reset_req, // Reset pulse
	input wire logic [7:0] tm0_count, // Timer value
	input wire logic tm0_running, // Timer busy
	input wire logic [3:0] wdt_count, // Watchdog value
	input wire logic wdt_slow, // Slow select
	input wire logic wdt_enabled // Option
);
	// ------------------------------------------------------------
	// Common frame
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	logic ld;
	// Any load overrides the count
	assign ld = tm0_lo_stb | tm0_hi_stb | tm0_imm_stb;

	// Final decrement and its landing on FF
	sequence last_step_s;
		tm0_running && tm0_count == 8'h00 && !ld && !mr0_wr_stb;
	endsequence
	sequence hit_ff_s;
		!tm0_running && tm0_count == 8'hFF;
	endsequence

	// ------------------------------------------------------------
	// Timer 0
	// ------------------------------------------------------------
	underflow_flag_a: assert property (last_step_s ##1 hit_ff_s |=> event_flags[1])
		else $error("underflow did not raise flag");
	stop_at_ff_a: assert property (last_step_s ##1 tm0_count == 8'hFF |-> !tm0_running)
		else $error("timer kept running past FF");
	start_run_a: assert property (
		mr0_wr_stb && mr0_data[3] && !ld && !tm0_running && !$past(tm0_running)
		|=> tm0_running && !event_flags[1]) else $error("start failed");
	stop_run_a: assert property (mr0_wr_stb && !mr0_data[3] |=> !tm0_running)
		else $error("stop failed");
	load_halt_a: assert property (ld |=> !tm0_running)
		else $error("load did not halt");
	imm_value_a: assert property (tm0_imm_stb |=> tm0_count == $past(tm0_data))
		else $error("full load value wrong");
	low_nibble_a: assert property (
		tm0_lo_stb && !tm0_imm_stb && !tm0_hi_stb
		|=> tm0_count == {$past(tm0_count[7:4]), $past(tm0_data[3:0])})
		else $error("low nibble load wrong");
	stopped_hold_a: assert property (!tm0_running && !ld && !mr0_wr_stb |=> $stable(tm0_count))
		else $error("stopped timer moved");
	flag_sticky_a: assert property (
		event_flags[1] && !(evf_clr_stb && evf_clr_mask[1]) && !(mr0_wr_stb && mr0_data[3])
		|=> event_flags[1]) else $error("flag dropped");
	irq_cause_a: assert property (tm0_irq |-> $past(event_flags[1]))
		else $error("request without flag");

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	wdt_off_a: assert property (!wdt_enabled [*2] |-> wdt_count == 4'h0)
		else $error("disabled watchdog counts");
	wdt_clear_a: assert property (wdt_clr_stb |=> wdt_count == 4'h0)
		else $error("clear missed");
	reset_pulse_a: assert property (chip_reset_req |-> wdt_count == 4'h0 ##1 !chip_reset_req)
		else $error("bad overflow pulse");
	slow_sel_a: assert property (
		(pmf_set_stb || pmf_clr_stb) && pmf_mask[3] |=> wdt_slow == $past(pmf_set_stb))
		else $error("prescale select wrong");
	rsv_bits_a: assert property ((pmf_set_stb || pmf_clr_stb) && !pmf_mask[3] |=> $stable(wdt_slow))
		else $error("reserved bit acted");
endmodule : dwt_checker

// [dwt_top_tb.sv]
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end

module dwt_top_tb;
	localparam int PS = 0, PC = 1, WC = 2, DC = 3, LO = 4, HI = 5, IM = 6, MR = 7;
	localparam int IE = 8, HE = 9, EC = 10;
	logic clk;
	logic nrst;
	logic opt_pin;
	logic [10:0] stb;
	logic [7:0] dat;
	logic [1:0] event_flags;
	logic div_irq;
	logic tm0_irq;
	logic div_hold_release;
	logic tm0_hold_release;
	logic chip_reset_req;
	logic [7:0] tm0_count;
	logic tm0_running;
	logic [3:0] wdt_count;
	logic wdt_slow;
	logic wdt_enabled;
	int cyc;
	int failures;
	int total_checks;
	int t0;
	int t1;
	int t2;
	int w0;

	// One data bus feeds every instruction operand
	dwt_top i_dwt_top (.wdt_option_pin(opt_pin), .pmf_set_stb(stb[PS]), .pmf_clr_stb(stb[PC]),
		.pmf_mask(dat[3:0]), .wdt_clr_stb(stb[WC]), .div_clr_stb(stb[DC]),
		.tm0_lo_stb(stb[LO]), .tm0_hi_stb(stb[HI]), .tm0_imm_stb(stb[IM]), .tm0_data(dat),
		.mr0_wr_stb(stb[MR]), .mr0_data(dat[3:0]), .ief_wr_stb(stb[IE]), .hef_wr_stb(stb[HE]),
		.en_data(dat[3:0]), .evf_clr_stb(stb[EC]), .evf_clr_mask(dat[1:0]), .*);

	// ------------------------------------------------------------
	// Clock, edge count and hang guard
	// ------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	initial begin
		#1600000;
		failures++;
		stop_test();
	end

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge clk) #2;
	endtask : cyc_wait

	// One-cycle instruction strobe; t0 marks the taking edge
	task automatic op(input int k, input logic [7:0] d);
		@(posedge clk) #2;
		stb[k] = 1'h1;
		dat = d;
		@(posedge clk) #2;
		stb = 11'h000;
		t0 = cyc;
	endtask : op

	// Bounded wait: event flag 0, timer stop, reset pulse, watchdog step
	task automatic wait_ev(input int sel, input int lim);
		int n;
		n = 0;
		while (!(sel == 0 ? event_flags[0] === 1'h1 : sel == 1 ? tm0_running === 1'h0 :
			sel == 2 ? chip_reset_req === 1'h1 : wdt_count !== 4'(w0)) && n < lim) begin
			cyc_wait(1);
			n++;
		end
		if (n >= lim) begin
			failures++;
			$display("BAD wait %0d exp event got none", sel);
		end
		t1 = cyc;
	endtask : wait_ev

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		nrst = 1'h0;
		opt_pin = 1'h0;
		stb = 11'h000;
		dat = 8'h00;
		failures = 0;
		total_checks = 0;
		repeat (6) @(posedge clk);
		#2 nrst = 1'h1;
		cyc_wait(1);
		`CHK("flags", 2'h0, event_flags)
		`CHK("slow", 1'h0, wdt_slow)
		// Fast prescale, preset 3
		op(IM, 8'h03);
		`CHK("imm", 8'h03, tm0_count)
		op(IE, 8'h02);
		op(HE, 8'h02);
		op(MR, 8'h08);
		`CHK("run", 1'h1, tm0_running)
		t2 = t0;
		wait_ev(1, 100);
		`CHK("ivl4", 16, t1 - t2)
		`CHK("ff", 8'hFF, tm0_count)
		cyc_wait(1);
		`CHK("uf flag", 1'h1, event_flags[1])
		cyc_wait(1);
		`CHK("irq", 1'h1, tm0_irq)
		`CHK("hold", 1'h1, tm0_hold_release)
		cyc_wait(8);
		`CHK("stay ff", 8'hFF, tm0_count)
		// Slow prescale, preset 1; start clears the old flag
		op(IM, 8'h01);
		op(MR, 8'h09);
		`CHK("flag clr", 1'h0, event_flags[1])
		t2 = t0;
		wait_ev(1, 3000);
		`CHK("ivl1024", 2048, t1 - t2)
		op(EC, 8'h02);
		`CHK("evf clr", 1'h0, event_flags[1])
		// Nibble loads; the low one breaks into a running count
		op(IM, 8'hF0);
		op(MR, 8'h08);
		cyc_wait(1);
		op(LO, 8'h05);
		`CHK("lo", 8'hF5, tm0_count)
		`CHK("lo halt", 1'h0, tm0_running)
		op(HI, 8'h0A);
		`CHK("hi", 8'hA5, tm0_count)
		op(MR, 8'h08);
		op(MR, 8'h00);
		`CHK("stop", 1'h0, tm0_running)
		// Watchdog option and fast tick
		`CHK("wdt off", 4'h0, wdt_count)
		opt_pin = 1'h1;
		cyc_wait(6);
		`CHK("wdt on", 1'h1, wdt_enabled)
		w0 = wdt_count;
		wait_ev(3, 1100);
		w0 = wdt_count;
		t2 = t1;
		wait_ev(3, 1100);
		`CHK("fast tick", 1024, t1 - t2)
		`CHK("wdt inc", 4'(w0 + 1), wdt_count)
		op(PS, 8'h07);
		`CHK("rsv", 1'h0, wdt_slow)
		op(PS, 8'h08);
		`CHK("slow on", 1'h1, wdt_slow)
		op(WC, 8'h00);
		`CHK("wdt clr", 4'h0, wdt_count)
		// Divider period, interrupt and upper-stage clear
		op(IE, 8'h01);
		op(HE, 8'h01);
		wait_ev(0, 17000);
		cyc_wait(1);
		`CHK("div irq", 1'h1, div_irq)
		`CHK("div hold", 1'h1, div_hold_release)
		op(EC, 8'h01);
		t2 = t1;
		w0 = wdt_count;
		wait_ev(0, 17000);
		`CHK("div period", 16384, t1 - t2)
		`CHK("slow tick", 4'(w0 + 1), wdt_count)
		op(EC, 8'h01);
		t2 = t1;
		while (cyc < t2 + 2000) cyc_wait(1);
		op(DC, 8'h00);
		wait_ev(0, 19000);
		`CHK("div clr", 17408, t1 - t2)
		// Unserviced watchdog overflows
		op(PC, 8'h08);
		`CHK("slow off", 1'h0, wdt_slow)
		op(WC, 8'h00);
		t2 = t0;
		wait_ev(2, 17500);
		`CHK("wdt late", 1'h1, t1 - t2 > 15360)
		`CHK("wdt wrap", 4'h0, wdt_count)
		opt_pin = 1'h0;
		cyc_wait(1100);
		`CHK("wdt dis", 4'h0, wdt_count)
		// Mid-run reset drops the slow prescale again
		op(PS, 8'h08);
		`CHK("slow set", 1'h1, wdt_slow)
		nrst = 1'h0;
		cyc_wait(2);
		nrst = 1'h1;
		cyc_wait(1);
		`CHK("slow rst", 1'h0, wdt_slow)
		stop_test();
	end
endmodule : dwt_top_tb

bind dwt_top dwt_checker #(.DIV_W(DIV_W), .WDT_W(WDT_W)) i_dwt_checker (.*);
